// File: swa_align_engine.sv
/*
 automatic sysref alignment search over clock inversion, coarse and fine
 aperture delay. assumes i_phase_late is an asynchronous comparator level that
 goes high once the internal clock falling edge reaches the sysref rising edge.
*/
`timescale 1ns/10ps
module swa_align_engine (
    input  wire logic       i_clock,      // device clock
    input  wire logic       i_rst,        // sync reset, high
    input  wire logic       i_go,         // align_cal_go level
    input  wire logic [7:0] i_setup,      // settle cycles per trial
    input  wire logic       i_phase_late, // async phase comparator
    output logic            o_busy,       // search running
    output logic            o_start,      // one-cycle start pulse
    output logic            o_done,       // one-cycle finish pulse
    output logic            o_inv,        // trial inversion
    output logic      [7:0] o_coarse,     // trial coarse delay
    output logic      [7:0] o_fine        // trial fine delay
);
    swa_pkg::swa_state_t state, next_state;
    logic       inv, next_inv, best_inv, next_best_inv;
    logic [7:0] coarse, next_coarse, fine, next_fine;
    logic [7:0] best_c, next_best_c;
    logic [8:0] wait_cnt, next_wait, reload;
    logic       go_d, s1, s2, s3, phase;
    logic       next_s1, next_s2, next_s3, next_phase;

    always_comb begin
        logic found, better, stop, fin_inv;
        logic [7:0] fin_c;
        found = 1'b0;
        better = 1'b0;
        stop = 1'b0;
        fin_inv = 1'b0;
        fin_c = '0;
        next_state = state;
        next_inv = inv;
        next_best_inv = best_inv;
        next_coarse = coarse;
        next_fine = fine;
        next_best_c = best_c;
        next_s1 = i_phase_late;
        next_s2 = s1;
        next_s3 = s2;
        next_phase = (s2 == s3) ? s3 : phase;
        // settle covers drive reg, synchroniser and phase reg, else stale reads
        reload = {1'b0, i_setup} + 9'(swa_pkg::COMP_PATH_LAT);
        next_wait = wait_cnt;
        o_start = (state == swa_pkg::SWA_IDLE) && i_go && !go_d;
        case (state)
            swa_pkg::SWA_IDLE: begin
                if (o_start) begin
                    next_state = swa_pkg::SWA_COARSE;
                    next_inv = 1'b0;
                    next_coarse = '0;
                    next_fine = '0;
                    next_best_inv = 1'b0;
                    next_best_c = swa_pkg::DLY_MAX;
                    next_wait = reload;
                end
            end
            swa_pkg::SWA_COARSE: begin
                found = phase || (coarse == swa_pkg::DLY_MAX);
                better = found && (!inv || (coarse < best_c));
                stop = found || (inv && (coarse == best_c));
                fin_inv = better ? inv : best_inv;
                fin_c = better ? coarse : best_c;
                if (!i_go) begin
                    next_state = swa_pkg::SWA_IDLE;
                end else if (wait_cnt != '0) begin
                    next_wait = wait_cnt - 9'd1;
                end else if (stop && !inv) begin
                    next_best_inv = fin_inv;
                    next_best_c = fin_c;
                    next_inv = 1'b1;
                    next_coarse = '0;
                    next_wait = reload;
                end else if (stop) begin
                    // back off one coarse step, then close in with fine
                    next_state = swa_pkg::SWA_FINE;
                    next_inv = fin_inv;
                    next_coarse = (fin_c == '0) ? '0 : fin_c - 8'd1;
                    next_fine = '0;
                    next_wait = reload;
                end else begin
                    next_coarse = coarse + 8'd1;
                    next_wait = reload;
                end
            end
            swa_pkg::SWA_FINE: begin
                if (!i_go) begin
                    next_state = swa_pkg::SWA_IDLE;
                end else if (wait_cnt != '0) begin
                    next_wait = wait_cnt - 9'd1;
                end else if (phase || (fine == swa_pkg::DLY_MAX)) begin
                    next_state = swa_pkg::SWA_DONE;
                end else begin
                    next_fine = fine + 8'd1;
                    next_wait = reload;
                end
            end
            swa_pkg::SWA_DONE: next_state = swa_pkg::SWA_IDLE;
            default: next_state = swa_pkg::SWA_IDLE;
        endcase
    end

    assign o_busy = (state == swa_pkg::SWA_COARSE) || (state == swa_pkg::SWA_FINE);
    assign o_done = (state == swa_pkg::SWA_DONE);
    assign o_inv = inv;
    assign o_coarse = coarse;
    assign o_fine = fine;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= swa_pkg::SWA_IDLE;
            inv <= 1'b0;
            best_inv <= 1'b0;
            coarse <= '0;
            fine <= '0;
            best_c <= '0;
            wait_cnt <= '0;
            go_d <= 1'b0;
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            phase <= 1'b0;
        end else begin
            state <= next_state;
            inv <= next_inv;
            best_inv <= next_best_inv;
            coarse <= next_coarse;
            fine <= next_fine;
            best_c <= next_best_c;
            wait_cnt <= next_wait;
            go_d <= i_go;
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            phase <= next_phase;
        end
    end

    a_inv_restart: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(inv) && o_busy |-> coarse == '0) else $error("inverted pass not from zero");
    a_fine_idle_coarse: assert property (@(posedge i_clock) disable iff (i_rst)
        state == swa_pkg::SWA_COARSE |-> fine == '0) else $error("fine moved in coarse pass");
endmodule

// File: swa_phase_map.sv
/*
 sysref phase map: synchronises the 24 delayed sysref samples, flags
 positions that sit near a sysref edge, and picks the capture position.
 assumes i_taps come from the analog delay line, asynchronous to i_clock.
*/
`timescale 1ns/10ps
module swa_phase_map (
    input  wire logic        i_clock,   // device clock
    input  wire logic        i_rst,     // sync reset, high
    input  wire logic [23:0] i_taps,    // sysref seen at each delay tap
    input  wire logic [3:0]  i_pick,    // chosen capture position
    output logic      [23:0] o_map,     // 1 = setup/hold risk
    output logic             o_capture  // sysref at chosen position
);
    logic [23:0] s1, s2, s3, tap, raw;
    logic [23:0] next_s1, next_s2, next_s3, next_tap, next_map;
    logic        next_capture;

    // a tap counts as changed only once the second and third stages agree
    always_comb begin
        next_s1 = i_taps;
        next_s2 = s1;
        next_s3 = s2;
        next_tap = (tap & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
        next_map = raw | swa_pkg::MAP_EDGE_MASK;
        next_capture = tap[i_pick];
    end

    assign raw[0] = 1'b1;
    assign raw[swa_pkg::MAP_W-1] = 1'b1;
    genvar k;
    generate
        for (k = 1; k < swa_pkg::MAP_W - 1; k++) begin : g_edge
            assign raw[k] = (tap[k] ^ tap[k-1]) | (tap[k] ^ tap[k+1]);
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            tap <= '0;
            o_map <= swa_pkg::MAP_EDGE_MASK;
            o_capture <= 1'b0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            tap <= next_tap;
            o_map <= next_map;
            o_capture <= next_capture;
        end
    end

    a_map_flags_edge: assert property (@(posedge i_clock) disable iff (i_rst)
        (tap[1] != tap[2]) |=> o_map[1]) else $error("map misses an edge");
    a_capture_pick: assert property (@(posedge i_clock) disable iff (i_rst)
        o_capture == $past(tap[i_pick])) else $error("wrong capture tap");
endmodule

// File: swa_pkg.sv
/*
 sysref window align package: register map, field layout, widths, states.
 assumes a byte-wide register port with 12-bit addresses.
*/
package swa_pkg;
    localparam int MAP_W      = 24;
    localparam int PICK_W     = 4;
    localparam int DLY_W      = 8;
    localparam int SYNC_DEPTH = 3;
    // drive register, comparator synchroniser and phase register
    localparam int COMP_PATH_LAT = SYNC_DEPTH + 2;

    localparam logic [11:0] ADDR_CLK_CTRL0  = 12'h029;
    localparam logic [11:0] ADDR_MAP_LOW    = 12'h02c;
    localparam logic [11:0] ADDR_MAP_MID    = 12'h02d;
    localparam logic [11:0] ADDR_MAP_HIGH   = 12'h02e;
    localparam logic [11:0] ADDR_CAL_SETUP  = 12'h2b0;
    localparam logic [11:0] ADDR_CAL_GO     = 12'h2b1;
    localparam logic [11:0] ADDR_CAL_STATUS = 12'h2b2;
    localparam logic [11:0] ADDR_CLOCK_INVERT_DELAY    = 12'h2b5;
    localparam logic [11:0] ADDR_COARSE_APERTURE_DELAY = 12'h2b6;
    localparam logic [11:0] ADDR_FINE_APERTURE_DELAY   = 12'h2b7;
    localparam logic [11:0] ADDR_RES_INV    = 12'h2b8;
    localparam logic [11:0] ADDR_RES_COARSE = 12'h2b9;
    localparam logic [11:0] ADDR_RES_FINE   = 12'h2ba;

    localparam int PICK_LSB      = 0;
    localparam int FINE_STEP_BIT = 4;
    localparam int GO_BIT        = 0;
    localparam int FINISHED_BIT  = 0;
    localparam int BUSY_BIT      = 1;

    localparam logic [7:0]  CLK_CTRL0_RESET = 8'h00;
    localparam logic [7:0]  CAL_SETUP_RESET = 8'h10;
    localparam logic [7:0]  DLY_MAX         = 8'hff;
    localparam logic [23:0] MAP_EDGE_MASK   = 24'h80_0001;

    typedef enum logic [1:0] {
        SWA_IDLE   = 2'b00,
        SWA_COARSE = 2'b01,
        SWA_FINE   = 2'b10,
        SWA_DONE   = 2'b11
    } swa_state_t;

    function automatic logic swa_hit(input logic [11:0] a, input logic [11:0] b);
        swa_hit = (a == b);
    endfunction
endpackage

// File: swa_sysref_source.sv
/*
 far side model: sysref edge seen across the 24 delay taps, and the phase
 comparator that trips once the total aperture delay reaches the target.
 assumes delay drive comes straight from the block's outputs.
*/
`timescale 1ns/10ps
module swa_sysref_source #(
    parameter int HALF_DLY = 600,  // inversion delay in fine units
    parameter int TARGET   = 1000  // delay where falling edge meets sysref
) (
    input  wire logic [4:0]  i_edge_pos,  // first tap that sees sysref high
    input  wire logic        i_inv,       // inversion drive
    input  wire logic [7:0]  i_coarse,    // coarse drive
    input  wire logic [7:0]  i_fine,      // fine drive
    output logic      [23:0] o_taps,      // sysref level per tap
    output logic             o_phase_late // comparator level
);
    int dly;
    always_comb begin
        for (int k = 0; k < 24; k++) begin
            o_taps[k] = (k >= int'(i_edge_pos));
        end
        // one coarse step spans the whole fine range here
        dly = (i_inv ? HALF_DLY : 0) + 256 * int'(i_coarse) + int'(i_fine);
        o_phase_late = (dly >= TARGET);
    end
endmodule

// File: swa_top.sv
/*
 sysref window align top: register file, phase map and alignment engine.
 assumes a byte register port (write strobe, read strobe) on i_clock and an
 analog aperture delay line steered by the delay outputs.
*/
`timescale 1ns/10ps
module swa_top (
    input  wire logic        i_clock,               // device clock, 50 MHz
    input  wire logic        i_rst,                 // sync reset, high
    input  wire logic [11:0] i_reg_addr,            // register address
    input  wire logic [7:0]  i_reg_wdata,           // write data
    input  wire logic        i_reg_wr,              // write strobe
    input  wire logic        i_reg_rd,              // read strobe
    output logic      [7:0]  o_reg_rdata,           // read data, next cycle
    input  wire logic [23:0] i_sysref_taps,         // sysref at each tap
    input  wire logic        i_phase_late,          // alignment comparator
    output logic             o_fine_step_select,    // tap spacing select
    output logic             o_sysref_capture,      // captured sysref
    output logic             o_clock_invert_delay,  // half-period delay
    output logic      [7:0]  o_coarse_aperture_delay, // coarse delay code
    output logic      [7:0]  o_fine_aperture_delay, // fine delay code
    output logic             o_align_cal_busy       // search running
);
    logic [7:0]  ctrl0, next_ctrl0;
    logic [7:0]  setup, next_setup;
    logic        go, next_go;
    logic        finished, next_finished;
    logic        clock_invert_delay, next_clock_invert_delay;
    logic [7:0]  coarse_aperture_delay, next_coarse_aperture_delay;
    logic [7:0]  fine_aperture_delay, next_fine_aperture_delay;
    logic        res_inv, next_res_inv;
    logic [7:0]  res_coarse, next_res_coarse;
    logic [7:0]  res_fine, next_res_fine;
    logic [7:0]  next_rdata;
    logic        next_out_inv;
    logic [7:0]  next_out_coarse, next_out_fine;
    logic        next_step;
    logic [23:0] map;
    logic        eng_busy, eng_start, eng_done, eng_inv;
    logic [7:0]  eng_coarse, eng_fine;

    swa_phase_map u_map (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_taps    (i_sysref_taps),
        .i_pick    (ctrl0[swa_pkg::PICK_LSB +: swa_pkg::PICK_W]),
        .o_map     (map),
        .o_capture (o_sysref_capture)
    );

    swa_align_engine u_eng (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_go         (go),
        .i_setup      (setup),
        .i_phase_late (i_phase_late),
        .o_busy       (eng_busy),
        .o_start      (eng_start),
        .o_done       (eng_done),
        .o_inv        (eng_inv),
        .o_coarse     (eng_coarse),
        .o_fine       (eng_fine)
    );

    // register writes; the engine result overrides a same-cycle manual write
    always_comb begin
        logic wr_ctrl, wr_inv, wr_coarse, wr_fine;
        wr_ctrl = i_reg_wr && swa_pkg::swa_hit(i_reg_addr, swa_pkg::ADDR_CLK_CTRL0);
        wr_inv = i_reg_wr && swa_pkg::swa_hit(i_reg_addr, swa_pkg::ADDR_CLOCK_INVERT_DELAY);
        wr_coarse = i_reg_wr && swa_pkg::swa_hit(i_reg_addr, swa_pkg::ADDR_COARSE_APERTURE_DELAY);
        wr_fine = i_reg_wr && swa_pkg::swa_hit(i_reg_addr, swa_pkg::ADDR_FINE_APERTURE_DELAY);
        next_ctrl0 = ctrl0;
        next_setup = setup;
        next_go = go;
        if (wr_ctrl) begin
            next_ctrl0 = i_reg_wdata;
        end
        if (i_reg_wr && swa_pkg::swa_hit(i_reg_addr, swa_pkg::ADDR_CAL_SETUP)) begin
            next_setup = i_reg_wdata;
        end
        if (i_reg_wr && swa_pkg::swa_hit(i_reg_addr, swa_pkg::ADDR_CAL_GO)) begin
            next_go = i_reg_wdata[swa_pkg::GO_BIT];
        end
        next_clock_invert_delay = wr_inv ? i_reg_wdata[0] : clock_invert_delay;
        next_coarse_aperture_delay = wr_coarse ? i_reg_wdata : coarse_aperture_delay;
        next_fine_aperture_delay = wr_fine ? i_reg_wdata : fine_aperture_delay;
        next_res_inv = res_inv;
        next_res_coarse = res_coarse;
        next_res_fine = res_fine;
        if (eng_done) begin
            // found delay stays in use after go is cleared
            next_clock_invert_delay = eng_inv;
            next_coarse_aperture_delay = eng_coarse;
            next_fine_aperture_delay = eng_fine;
            next_res_inv = eng_inv;
            next_res_coarse = eng_coarse;
            next_res_fine = eng_fine;
        end
        // start and finish never coincide, so set cannot be lost here
        next_finished = eng_done ? 1'b1 : (eng_start ? 1'b0 : finished);
    end

    // register reads: one cycle latency, unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        case (i_reg_addr)
            swa_pkg::ADDR_CLK_CTRL0:  next_rdata = ctrl0;
            swa_pkg::ADDR_MAP_LOW:    next_rdata = map[7:0];
            swa_pkg::ADDR_MAP_MID:    next_rdata = map[15:8];
            swa_pkg::ADDR_MAP_HIGH:   next_rdata = map[23:16];
            swa_pkg::ADDR_CAL_SETUP:  next_rdata = setup;
            swa_pkg::ADDR_CAL_GO:     next_rdata = {7'h00, go};
            swa_pkg::ADDR_CAL_STATUS: next_rdata = {6'h00, eng_busy, finished};
            swa_pkg::ADDR_CLOCK_INVERT_DELAY:    next_rdata = {7'h00, clock_invert_delay};
            swa_pkg::ADDR_COARSE_APERTURE_DELAY: next_rdata = coarse_aperture_delay;
            swa_pkg::ADDR_FINE_APERTURE_DELAY:   next_rdata = fine_aperture_delay;
            swa_pkg::ADDR_RES_INV:    next_rdata = {7'h00, res_inv};
            swa_pkg::ADDR_RES_COARSE: next_rdata = res_coarse;
            swa_pkg::ADDR_RES_FINE:   next_rdata = res_fine;
            default:                  next_rdata = '0;
        endcase
        if (!i_reg_rd) begin
            next_rdata = o_reg_rdata;
        end
    end

    // aperture delay drive: trial values while searching, else the registers
    always_comb begin
        // done cycle keeps the found delay, so the line never dips to stale values
        next_out_inv = (eng_busy || eng_done) ? eng_inv : clock_invert_delay;
        next_out_coarse = (eng_busy || eng_done) ? eng_coarse : coarse_aperture_delay;
        next_out_fine = (eng_busy || eng_done) ? eng_fine : fine_aperture_delay;
        next_step = ctrl0[swa_pkg::FINE_STEP_BIT];
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl0 <= swa_pkg::CLK_CTRL0_RESET;
            setup <= swa_pkg::CAL_SETUP_RESET;
            go <= 1'b0;
            finished <= 1'b0;
            clock_invert_delay <= 1'b0;
            coarse_aperture_delay <= '0;
            fine_aperture_delay <= '0;
            res_inv <= 1'b0;
            res_coarse <= '0;
            res_fine <= '0;
            o_reg_rdata <= '0;
            o_clock_invert_delay <= 1'b0;
            o_coarse_aperture_delay <= '0;
            o_fine_aperture_delay <= '0;
            o_fine_step_select <= 1'b0;
            o_align_cal_busy <= 1'b0;
        end else begin
            ctrl0 <= next_ctrl0;
            setup <= next_setup;
            go <= next_go;
            finished <= next_finished;
            clock_invert_delay <= next_clock_invert_delay;
            coarse_aperture_delay <= next_coarse_aperture_delay;
            fine_aperture_delay <= next_fine_aperture_delay;
            res_inv <= next_res_inv;
            res_coarse <= next_res_coarse;
            res_fine <= next_res_fine;
            o_reg_rdata <= next_rdata;
            o_clock_invert_delay <= next_out_inv;
            o_coarse_aperture_delay <= next_out_coarse;
            o_fine_aperture_delay <= next_out_fine;
            o_fine_step_select <= next_step;
            o_align_cal_busy <= eng_busy;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_map_outer_bits: assert property (
        map[0] && map[23]) else $error("outer map bits not set");
    a_map_read_low: assert property (
        i_reg_rd && i_reg_addr == swa_pkg::ADDR_MAP_LOW |=> o_reg_rdata == $past(map[7:0])
    ) else $error("map low read wrong");
    a_map_read_high: assert property (
        i_reg_rd && i_reg_addr == swa_pkg::ADDR_MAP_HIGH |=> o_reg_rdata == $past(map[23:16])
    ) else $error("map high read wrong");
    a_ctrl_after_reset: assert property (
        $past(i_rst) |-> ctrl0 == swa_pkg::CLK_CTRL0_RESET
    ) else $error("control register reset wrong");
    a_pick_write: assert property (
        i_reg_wr && i_reg_addr == swa_pkg::ADDR_CLK_CTRL0 |=> ctrl0[3:0] == $past(i_reg_wdata[3:0])
    ) else $error("position select not stored");
    a_step_write: assert property (
        i_reg_wr && i_reg_addr == swa_pkg::ADDR_CLK_CTRL0 |-> ##2 o_fine_step_select == $past(i_reg_wdata[4], 2)
    ) else $error("step select not applied");
    a_start_clears: assert property (
        eng_start |=> !finished && eng_busy
    ) else $error("start did not clear finished");
    a_done_sets: assert property (
        eng_done |=> finished ##1 o_coarse_aperture_delay == $past(eng_coarse, 2)
    ) else $error("finish flag or result missing");
    a_result_kept: assert property (
        eng_done |=> res_coarse == coarse_aperture_delay && res_fine == fine_aperture_delay && res_inv == clock_invert_delay
    ) else $error("result not applied");
    a_trial_drive: assert property (
        eng_busy |=> o_coarse_aperture_delay == $past(eng_coarse) && o_fine_aperture_delay == $past(eng_fine)
    ) else $error("trial delay not driven");

    c_search_done: cover property (eng_start ##[1:1000] eng_done);
    c_done_inverted: cover property (eng_done && eng_inv);
    c_map_read: cover property (i_reg_rd && i_reg_addr == swa_pkg::ADDR_MAP_MID);
    c_abort: cover property (eng_busy ##1 !go);
endmodule

// File: test_sysref_window_align.sv
/*
 self-checking bench for swa_top: register port tasks, phase map, capture
 select and the alignment search. assumes swa_sysref_source as far side.
*/
`timescale 1ns/10ps
module test_sysref_window_align;
    logic i_clock = 0, i_rst = 1, wr = 0, rd = 0, inv, late;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, rdata, coarse, fine, v;
    logic [23:0] taps;
    logic [4:0] edge_pos = 5'h09;
    logic fstep, cap, busy;
    int num_errors = 0, check_count = 0, cyc = 0;
    always #10 i_clock = ~i_clock;
    swa_top u_swa_top (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_sysref_taps(taps), .i_phase_late(late),
        .o_fine_step_select(fstep), .o_sysref_capture(cap), .o_clock_invert_delay(inv),
        .o_coarse_aperture_delay(coarse), .o_fine_aperture_delay(fine), .o_align_cal_busy(busy));
    swa_sysref_source u_swa_sysref_source (.i_edge_pos(edge_pos), .i_inv(inv), .i_coarse(coarse),
        .i_fine(fine), .o_taps(taps), .o_phase_late(late));
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clock);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, output logic [7:0] d);
        @(posedge i_clock);
        rd <= 1'b1; addr <= a;
        @(posedge i_clock);
        rd <= 1'b0;
        @(posedge i_clock);
        #1 d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        logic [23:0] m;
        int pos [3] = '{9, 1, 22};
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        rreg(12'h029, v); check("ctrl0 reset", v, 8'h00);
        foreach (pos[i]) begin
            edge_pos <= pos[i][4:0];
            settle(8);
            m = 24'h80_0001 | (24'h1 << (pos[i] - 1)) | (24'h1 << pos[i]);
            rreg(12'h02c, v); check("map low", v, m[7:0]);
            rreg(12'h02d, v); check("map mid", v, m[15:8]);
            rreg(12'h02e, v); check("map high", v, m[23:16]);
        end
        $display("test phase map done");
        edge_pos <= 5'h09;
        wreg(12'h029, 8'h1c); settle(8);
        rreg(12'h029, v); check("ctrl0", v, 8'h1c);
        check("fine step", fstep, 1'b1);
        check("capture pos 12", cap, 1'b1);
        wreg(12'h029, 8'h08); settle(4);
        check("coarse step", fstep, 1'b0);
        check("capture pos 8", cap, 1'b0);
        wreg(12'h029, 8'h0f); settle(4);
        check("capture pos 15", cap, 1'b1);
        wreg(12'h02c, 8'h55);
        rreg(12'h02c, v); check("map ro", v, 8'h01);
        rreg(12'h3ff, v); check("unmapped", v, 8'h00);
        $display("test capture select done");
        wreg(12'h029, 8'h00);
        rreg(12'h2b0, v); check("setup reset", v, 8'h10);
        wreg(12'h2b0, 8'h00);
        wreg(12'h2b1, 8'h01); settle(20);
        check("busy", busy, 1'b1);
        wreg(12'h2b1, 8'h00); settle(6);
        rreg(12'h2b2, v); check("abort status", v, 8'h00);
        $display("test abort done");
        wreg(12'h2b1, 8'h01);
        v = 8'h00;
        for (int i = 0; i < 1500 && v[0] !== 1'b1; i++) begin
            rreg(12'h2b2, v);
        end
        check("finished", v, 8'h01);
        rreg(12'h2b8, v); check("res inv", v, 8'h01);
        rreg(12'h2b9, v); check("res coarse", v, 8'h01);
        rreg(12'h2ba, v); check("res fine", v, 8'h90);
        check("aligned", late, 1'b1);
        wreg(12'h2b1, 8'h00); settle(4);
        check("delay kept", {inv, coarse, fine}, {1'b1, 8'h01, 8'h90});
        wreg(12'h2b6, 8'h05); settle(4);
        check("manual coarse", coarse, 8'h05);
        wreg(12'h2b5, 8'h00); settle(4);
        check("manual invert", inv, 1'b0);
        $display("test alignment done");
        end_of_test();
    end
endmodule
